// ### rtl/urx_map.svh
// Register offsets, field positions, reset values and timing counts of the receiver
`ifndef URX_MAP_SVH
`define URX_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define URX_CTRL_OFS 12'h000
`define URX_STAT_OFS 12'h004
`define URX_DATA_OFS 12'h008
`define URX_BAUD_OFS 12'h00C

// ****************************************
// Control register fields
// ****************************************
`define URX_C_RECEIVER_ENABLE   0
`define URX_C_NINE   1
`define URX_C_PARITY_CHECK_ENABLE   2
`define URX_C_ODD    3
`define URX_C_TWOSTP 4
`define URX_C_ADDRESS_QUALIFY_ENABLE  5
`define URX_C_RIE    6
`define URX_C_TEIE   7
`define URX_C_TIIE   8
`define URX_C_WAKE   9
`define URX_C_BIT9   16
`define URX_CTRL_W   10
`define URX_CTRL_RST 10'h000

// ****************************************
// Status register fields
// ****************************************
`define URX_S_PARITY_ERROR_FLAG  0
`define URX_S_FRAMING_ERROR_FLAG  1
`define URX_S_NF    2
`define URX_S_OVERRUN_FLAG  3
`define URX_S_QUIET 4
`define URX_S_RX_DATA_AVAILABLE_FLAG  5
`define URX_S_TXE   6
`define URX_S_TXI   7

// ****************************************
// Baud and oversampling
// ****************************************
`define URX_BAUD_RST 16'h0040
`define URX_OVS_LAST 4'hF
`define URX_SMP_A    4'h7
`define URX_SMP_B    4'h8
`define URX_SMP_C    4'h9

`endif

// ### rtl/urx_pkg.sv
// Types shared by the serial receiver
package urx_pkg;
	typedef enum logic [2:0] {
		URX_IDLE,
		URX_START,
		URX_DATA,
		URX_STOP1,
		URX_STOP2,
		URX_WAIT_HIGH
	} urx_state_type;

	// Buffered entry: noise, framing, parity, nine data bits
	typedef logic [11:0] urx_entry_type;
endpackage

// ### rtl/urx_receiver.sv
// Serial receiver with two-word buffer, error flags and interrupt combiner
//
// Functional notes
// - Shift frame in least significant bit first
// - Buffer holds two words, third shifting
// - Third word on full buffer: drop, overrun
// - Enable bit starts start-bit search
// - Data-available set while buffer non-empty
// - Word buffered with irq enable interrupts
// - Break: framing error, zero word, idle
// - After bad stop, wait line high
// - Idle flag low start to stop
// - Noise flagged with word, no own irq
// - Low stop bit sets framing error
// - Parity error only with parity enabled
// - Parity, framing, noise stored per buffered word
// - Five sources form one low pulse
// - Tx sources own enables, rx share
// - Only the wake source has no flag
// - Status flags read-only, hardware cleared
// - Address mode: interrupt on high top bit
// - Ninth bit shown in control register
// - Sixteen-times sampling, three-sample vote
// - Stop sampled: move word into buffer
`timescale 1ns/10ps
`include "urx_map.svh"

module urx_receiver #(
	parameter int FIFO_DEPTH = 2,
	parameter int BAUD_W     = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_pin,
	input  wire logic        tx_empty_cond,
	input  wire logic        tx_idle_cond,
	output logic             irq_n
);

	localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(FIFO_DEPTH);

	function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
		reg_hit = (a[11:2] == ofs[11:2]);
	endfunction

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
	endfunction

	// ****************************************
	// Storage
	// ****************************************
	logic [31:0]               prdata_ff;
	logic                      pready_ff;
	logic                      pslverr_ff;
	logic                      irq_n_ff;
	logic [`URX_CTRL_W-1:0]    ctrl_ff;
	logic [BAUD_W-1:0]         baud_divider_ff;
	logic [BAUD_W-1:0]         baud_cnt_ff;
	logic                      tick_ff;
	logic                      rx_meta_ff;
	logic                      rx_sync_ff;
	logic                      rx_prev_ff;
	urx_pkg::urx_state_type    state_ff;
	logic [3:0]                os_cnt_ff;
	logic [1:0]                smp_ff;
	logic [3:0]                bit_cnt_ff;
	logic [8:0]                rx_shift_register_ff;
	logic                      noise_acc_ff;
	logic                      receiver_quiet_flag_ff;
	logic                      overrun_flag_ff;
	logic                      stat_seen_ff;
	logic                      tx_empty_prev_ff;
	logic                      tx_idle_prev_ff;
	urx_pkg::urx_entry_type    fifo_mem [FIFO_DEPTH];
	logic [PTR_W-1:0]          wr_ptr_ff;
	logic [PTR_W-1:0]          rd_ptr_ff;
	logic [CNT_W-1:0]          count_ff;

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq_n   = irq_n_ff;

	// ****************************************
	// Bus decode
	// ****************************************
	logic                   access;
	logic                   fire;
	logic                   mapped;
	logic                   data_rd;
	logic                   stat_rd;
	logic                   receiver_enable;
	logic                   nine_bit;
	logic                   two_stop;
	logic                   receive_irq_enable;
	urx_pkg::urx_entry_type head;
	logic                   rx_data_available_flag;
	logic [7:0]             status_val;
	logic [31:0]            rd_mux;

	assign access  = psel && penable && !pready_ff;
	assign fire    = psel && penable && pready_ff;
	assign mapped  = reg_hit(paddr, `URX_CTRL_OFS) || reg_hit(paddr, `URX_STAT_OFS) ||
		reg_hit(paddr, `URX_DATA_OFS) || reg_hit(paddr, `URX_BAUD_OFS);
	assign data_rd = fire && !pwrite && reg_hit(paddr, `URX_DATA_OFS);
	assign stat_rd = fire && !pwrite && reg_hit(paddr, `URX_STAT_OFS);

	assign receiver_enable    = ctrl_ff[`URX_C_RECEIVER_ENABLE];
	assign nine_bit           = ctrl_ff[`URX_C_NINE];
	assign two_stop           = ctrl_ff[`URX_C_TWOSTP];
	assign receive_irq_enable = ctrl_ff[`URX_C_RIE];
	assign head               = fifo_mem[rd_ptr_ff];
	assign rx_data_available_flag = (count_ff != '0);

	always_comb begin
		status_val = 8'h00;
		status_val[`URX_S_PARITY_ERROR_FLAG]  = rx_data_available_flag && head[9];
		status_val[`URX_S_FRAMING_ERROR_FLAG]  = rx_data_available_flag && head[10];
		status_val[`URX_S_NF]    = rx_data_available_flag && head[11];
		status_val[`URX_S_OVERRUN_FLAG]  = overrun_flag_ff;
		status_val[`URX_S_QUIET] = receiver_quiet_flag_ff;
		status_val[`URX_S_RX_DATA_AVAILABLE_FLAG]  = rx_data_available_flag;
		status_val[`URX_S_TXE]   = tx_empty_cond;
		status_val[`URX_S_TXI]   = tx_idle_cond;
		rd_mux = 32'h0000_0000;
		if (reg_hit(paddr, `URX_CTRL_OFS)) begin
			rd_mux[`URX_CTRL_W-1:0] = ctrl_ff;
			rd_mux[`URX_C_BIT9] = rx_data_available_flag && head[8];
		end else if (reg_hit(paddr, `URX_STAT_OFS)) begin
			rd_mux[7:0] = status_val;
		end else if (reg_hit(paddr, `URX_DATA_OFS)) begin
			rd_mux[8:0] = rx_data_available_flag ? head[8:0] : 9'h000;
		end else if (reg_hit(paddr, `URX_BAUD_OFS)) begin
			rd_mux[BAUD_W-1:0] = baud_divider_ff;
		end
	end

	// ****************************************
	// APB slave, one wait state
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= access;
			pslverr_ff <= access && !mapped;
			if (access && !pwrite) begin
				prdata_ff <= rd_mux;
			end else if (fire) begin
				prdata_ff <= 32'h0000_0000;
			end
		end
	end

	// Status bits have no write path at all
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff         <= `URX_CTRL_RST;
			baud_divider_ff <= BAUD_W'(`URX_BAUD_RST);
		end else if (fire && pwrite) begin
			if (reg_hit(paddr, `URX_CTRL_OFS)) begin
				ctrl_ff <= pwdata[`URX_CTRL_W-1:0];
			end
			if (reg_hit(paddr, `URX_BAUD_OFS)) begin
				baud_divider_ff <= pwdata[BAUD_W-1:0];
			end
		end
	end

	// ****************************************
	// Oversampling tick and pin synchroniser
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_cnt_ff <= '0;
			tick_ff     <= 1'b0;
		end else if (!receiver_enable || baud_cnt_ff == '0) begin
			baud_cnt_ff <= baud_divider_ff;
			tick_ff     <= receiver_enable;
		end else begin
			baud_cnt_ff <= BAUD_W'(baud_cnt_ff - 1'b1);
			tick_ff     <= 1'b0;
		end
	end

	// Idle-high reset values avoid a false start after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
		end else begin
			rx_meta_ff <= rx_pin;
			rx_sync_ff <= rx_meta_ff;
			rx_prev_ff <= rx_sync_ff;
		end
	end

	// ****************************************
	// Bit recovery
	// ****************************************
	logic       decide;
	logic       vote;
	logic       vote_noise;
	logic [3:0] last_bit;
	logic       done;
	logic       done_framing_error_flag;
	logic       done_parity_error_flag;
	logic       space;
	logic       push;
	logic       pop;

	assign decide     = tick_ff && (os_cnt_ff == `URX_SMP_C) &&
		(state_ff != urx_pkg::URX_IDLE) && (state_ff != urx_pkg::URX_WAIT_HIGH);
	assign vote       = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & rx_sync_ff) |
		(smp_ff[1] & rx_sync_ff);
	assign vote_noise = !((smp_ff[0] == smp_ff[1]) && (smp_ff[1] == rx_sync_ff));
	assign last_bit   = nine_bit ? 4'h8 : 4'h7;
	assign done       = decide && ((state_ff == urx_pkg::URX_STOP2) ||
		((state_ff == urx_pkg::URX_STOP1) && !(two_stop && vote)));
	assign done_framing_error_flag  = !vote;
	assign done_parity_error_flag  = ctrl_ff[`URX_C_PARITY_CHECK_ENABLE] &&
		((^(rx_shift_register_ff & (nine_bit ? 9'h1FF : 9'h0FF))) != ctrl_ff[`URX_C_ODD]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff  <= urx_pkg::URX_IDLE;
			os_cnt_ff <= 4'h0;
			smp_ff    <= 2'h3;
		end else if (!receiver_enable) begin
			state_ff <= urx_pkg::URX_IDLE;
		end else if (tick_ff) begin
			os_cnt_ff <= (os_cnt_ff == `URX_OVS_LAST) ? 4'h0 : 4'(os_cnt_ff + 1'b1);
			if (os_cnt_ff == `URX_SMP_A || os_cnt_ff == `URX_SMP_B) begin
				smp_ff <= {smp_ff[0], rx_sync_ff};
			end
			case (state_ff)
				urx_pkg::URX_IDLE: begin
					if (!rx_sync_ff) begin
						state_ff  <= urx_pkg::URX_START;
						os_cnt_ff <= 4'h1;
					end
				end
				urx_pkg::URX_START: begin
					if (decide) begin
						state_ff <= vote ? urx_pkg::URX_IDLE : urx_pkg::URX_DATA;
					end
				end
				urx_pkg::URX_DATA: begin
					if (decide && bit_cnt_ff == last_bit) begin
						state_ff <= urx_pkg::URX_STOP1;
					end
				end
				urx_pkg::URX_STOP1, urx_pkg::URX_STOP2: begin
					if (done) begin
						state_ff <= done_framing_error_flag ? urx_pkg::URX_WAIT_HIGH : urx_pkg::URX_IDLE;
					end else if (decide) begin
						state_ff <= urx_pkg::URX_STOP2;
					end
				end
				urx_pkg::URX_WAIT_HIGH: begin
					if (rx_sync_ff) begin
						state_ff <= urx_pkg::URX_IDLE;
					end
				end
				default: begin
					state_ff <= urx_pkg::URX_IDLE;
				end
			endcase
		end
	end

	// Shift and noise capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_ff           <= 4'h0;
			rx_shift_register_ff <= 9'h000;
			noise_acc_ff         <= 1'b0;
		end else if (tick_ff && state_ff == urx_pkg::URX_IDLE) begin
			bit_cnt_ff           <= 4'h0;
			rx_shift_register_ff <= 9'h000;
			noise_acc_ff         <= 1'b0;
		end else if (decide) begin
			noise_acc_ff <= noise_acc_ff | vote_noise;
			if (state_ff == urx_pkg::URX_DATA) begin
				rx_shift_register_ff[bit_cnt_ff] <= vote;
				bit_cnt_ff <= 4'(bit_cnt_ff + 1'b1);
			end
		end
	end

	// Quiet from final stop sample until the next start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receiver_quiet_flag_ff <= 1'b1;
		end else if (tick_ff && state_ff == urx_pkg::URX_IDLE && !rx_sync_ff && receiver_enable) begin
			receiver_quiet_flag_ff <= 1'b0;
		end else if (done || (decide && state_ff == urx_pkg::URX_START && vote)) begin
			receiver_quiet_flag_ff <= 1'b1;
		end
	end

	// ****************************************
	// Two-word receive buffer
	// ****************************************
	assign pop   = data_rd && rx_data_available_flag;
	assign space = (count_ff != FULL_CNT) || pop;
	assign push  = done && space;

	// A break arrives as an all-zero word with the framing error set
	always_ff @(posedge pclk) begin
		if (push) begin
			fifo_mem[wr_ptr_ff] <= {noise_acc_ff, done_framing_error_flag, done_parity_error_flag,
				rx_shift_register_ff};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= ptr_inc(wr_ptr_ff);
			end
			if (pop) begin
				rd_ptr_ff <= ptr_inc(rd_ptr_ff);
			end
			if (push && !pop) begin
				count_ff <= CNT_W'(count_ff + 1'b1);
			end else if (pop && !push) begin
				count_ff <= CNT_W'(count_ff - 1'b1);
			end
		end
	end

	// ****************************************
	// Overrun and clearing sequence
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_seen_ff <= 1'b0;
		end else if (stat_rd) begin
			stat_seen_ff <= 1'b1;
		end else if (data_rd) begin
			stat_seen_ff <= 1'b0;
		end
	end

	// New overrun beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun_flag_ff <= 1'b0;
		end else if (done && !space) begin
			overrun_flag_ff <= 1'b1;
		end else if (data_rd && stat_seen_ff) begin
			overrun_flag_ff <= 1'b0;
		end
	end

	// ****************************************
	// Interrupt combiner
	// ****************************************
	logic top_bit;
	logic ev_rx;
	logic ev_ovr;
	logic ev_txe;
	logic ev_txi;
	logic ev_wake;

	assign top_bit = nine_bit ? rx_shift_register_ff[8] : rx_shift_register_ff[7];
	assign ev_rx   = push && receive_irq_enable &&
		(!ctrl_ff[`URX_C_ADDRESS_QUALIFY_ENABLE] || top_bit);
	assign ev_ovr  = done && !space && receive_irq_enable;
	assign ev_txe  = tx_empty_cond && !tx_empty_prev_ff && ctrl_ff[`URX_C_TEIE];
	assign ev_txi  = tx_idle_cond && !tx_idle_prev_ff && ctrl_ff[`URX_C_TIIE];
	assign ev_wake = rx_prev_ff && !rx_sync_ff && receiver_enable &&
		receiver_quiet_flag_ff && ctrl_ff[`URX_C_WAKE] && receive_irq_enable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_empty_prev_ff <= 1'b0;
			tx_idle_prev_ff  <= 1'b0;
			irq_n_ff         <= 1'b1;
		end else begin
			tx_empty_prev_ff <= tx_empty_cond;
			tx_idle_prev_ff  <= tx_idle_cond;
			irq_n_ff         <= !(ev_rx || ev_ovr || ev_txe || ev_txi || ev_wake);
		end
	end

endmodule

// ### testbench/uart_receiver_with_errors_tb_top.sv
// Self-checking bench for the serial receiver
`timescale 1ns/10ps
`include "urx_map.svh"
module uart_receiver_with_errors_tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_pin;
	logic        txe;
	logic        txi;
	logic        irq_n;
	logic [31:0] r;
	logic        er;
	logic [8:0]  d;
	logic [7:0]  v [3];
	int          mismatches = 0;
	int          samples_checked = 0;
	int          irqs = 0;
	int          n0;
	urx_receiver i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_pin(rx_pin), .tx_empty_cond(txe), .tx_idle_cond(txi),
		.irq_n(irq_n));
	urx_serial_tx i_tx (.pclk(pclk), .rx_pin(rx_pin));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (irq_n === 1'b0) begin
			irqs <= irqs + 1;
		end
	end
	// ****
	// Shared tasks
	// ****
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 10);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			mismatches++;
			summarize();
		end
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, r, e);
	endtask
	task automatic tx(input logic [8:0] dd, input int n, input logic stp);
		i_tx.send(dd, n, stp);
		repeat (4) @(posedge pclk);
	endtask
	function automatic logic [31:0] st(input logic pe, fe, ov, rx);
		return {24'h0, txi, txe, rx, 1'b1, ov, 1'b0, fe, pe};
	endfunction
	// ****
	// Main sequence
	// ****
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		txe = 1'b0;
		txi = 1'b0;
		void'($urandom(32'h5068));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rc(`URX_CTRL_OFS, 32'h0, "ctrl");
		rc(`URX_BAUD_OFS, 32'h40, "baud");
		apb(1'b1, `URX_STAT_OFS, 32'hFF);
		rc(`URX_STAT_OFS, st(0, 0, 0, 0), "stat");
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", er, 32'h1);
		tx(9'h055, 8, 1'b1);
		rc(`URX_STAT_OFS, st(0, 0, 0, 0), "off");
		apb(1'b1, `URX_BAUD_OFS, 32'h0);
		apb(1'b1, `URX_CTRL_OFS, 32'h41);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			d = 9'($urandom);
			d[8] = 1'b0;
			n0 = irqs;
			tx(d, 8, 1'b1);
			chk("irq", irqs - n0, 32'h1);
			rc(`URX_STAT_OFS, st(0, 0, 0, 1), "avail");
			rc(`URX_DATA_OFS, d, "data");
			rc(`URX_STAT_OFS, st(0, 0, 0, 0), "clear");
		end
		$display("test frames done");
		n0 = irqs;
		for (int i = 0; i < 3; i++) begin
			v[i] = 8'($urandom);
			tx(v[i], 8, 1'b1);
		end
		chk("ovr irq", irqs - n0, 32'h3);
		rc(`URX_STAT_OFS, st(0, 0, 1, 1), "ovr");
		rc(`URX_DATA_OFS, v[0], "w0");
		rc(`URX_DATA_OFS, v[1], "w1");
		rc(`URX_STAT_OFS, st(0, 0, 0, 0), "ovr clr");
		n0 = irqs;
		tx(9'h000, 8, 1'b0);
		chk("brk irq", irqs - n0, 32'h1);
		rc(`URX_STAT_OFS, st(0, 1, 0, 1), "brk");
		rc(`URX_DATA_OFS, 32'h0, "brk data");
		rc(`URX_STAT_OFS, st(0, 0, 0, 0), "one");
		n0 = irqs;
		i_tx.glitch = 3;
		tx(9'h0C3, 8, 1'b1);
		i_tx.glitch = -1;
		chk("noise irq", irqs - n0, 32'h1);
		rc(`URX_STAT_OFS, st(0, 0, 0, 1) | 32'h4, "noise");
		rc(`URX_DATA_OFS, 32'hC3, "noise d");
		rc(`URX_STAT_OFS, st(0, 0, 0, 0), "noise clr");
		// Ninth bit high acts as the first stop, the low stop as the second
		apb(1'b1, `URX_CTRL_OFS, 32'h51);
		tx(9'h1C3, 9, 1'b0);
		rc(`URX_STAT_OFS, st(0, 1, 0, 1), "stop2");
		rc(`URX_DATA_OFS, 32'hC3, "stop2 d");
		tx(9'h03C, 8, 1'b1);
		rc(`URX_STAT_OFS, st(0, 0, 0, 1), "two ok");
		rc(`URX_DATA_OFS, 32'h3C, "two d");
		$display("test errors done");
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `URX_CTRL_OFS, 32'h45 | ((k & 1) << 3));
			d = 9'($urandom);
			d[7] = ^d[6:0] ^ k[0] ^ k[1];
			tx(d, 8, 1'b1);
			rc(`URX_STAT_OFS, st(k[1], 0, 0, 1), "par");
			rc(`URX_DATA_OFS, d[7:0], "par data");
		end
		apb(1'b1, `URX_CTRL_OFS, 32'h63);
		for (int k = 0; k < 2; k++) begin
			d = 9'($urandom);
			d[8] = k[0];
			n0 = irqs;
			tx(d, 9, 1'b1);
			chk("adr irq", irqs - n0, k);
			rc(`URX_CTRL_OFS, 32'h63 | (k << 16), "ninth");
			rc(`URX_DATA_OFS, d, "d9");
		end
		// Divider of one doubles the bit time
		apb(1'b1, `URX_BAUD_OFS, 32'h1);
		apb(1'b1, `URX_CTRL_OFS, 32'h41);
		i_tx.bit_cyc = 32;
		d = 9'($urandom);
		tx(d[7:0], 8, 1'b1);
		rc(`URX_DATA_OFS, d[7:0], "slow");
		i_tx.bit_cyc = 16;
		apb(1'b1, `URX_BAUD_OFS, 32'h0);
		$display("test modes done");
		apb(1'b1, `URX_CTRL_OFS, 32'h80);
		n0 = irqs;
		txe <= 1'b1;
		txi <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("tx irq", irqs - n0, 32'h1);
		rc(`URX_STAT_OFS, st(0, 0, 0, 0), "tx st");
		apb(1'b1, `URX_CTRL_OFS, 32'h100);
		txe <= 1'b0;
		txi <= 1'b0;
		repeat (2) @(posedge pclk);
		n0 = irqs;
		txe <= 1'b1;
		txi <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("idle irq", irqs - n0, 32'h1);
		apb(1'b1, `URX_CTRL_OFS, 32'h241);
		n0 = irqs;
		tx(9'h0A5, 8, 1'b1);
		chk("wake irq", irqs - n0, 32'h2);
		rc(`URX_DATA_OFS, 32'hA5, "wake d");
		$display("test sources done");
		tx(9'h000, 8, 1'b0);
		rc(`URX_STAT_OFS, st(0, 1, 0, 1), "brk2");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rc(`URX_STAT_OFS, st(0, 0, 0, 0), "rst stat");
		rc(`URX_DATA_OFS, 32'h0, "rst data");
		rc(`URX_BAUD_OFS, 32'h40, "rst baud");
		$display("test midrun reset done");
		summarize();
	end
endmodule

// ### testbench/urx_props.sv
// Port-level assertion checker for the serial receiver
`timescale 1ns/10ps
`include "urx_map.svh"
module urx_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rx_pin,
	input wire logic        tx_empty_cond,
	input wire logic        tx_idle_cond,
	input wire logic        irq_n
);
	// ****
	// Shadow of the interrupt enables
	// ****
	logic [9:0] ctrl_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= 10'h000;
		end else if (psel && penable && pready && pwrite && paddr == `URX_CTRL_OFS) begin
			ctrl_ff <= pwdata[9:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wait;
		!pready ##1 pready;
	endsequence
	AST_APB_WAIT: assert property (s_setup ##1 (psel && penable) |-> s_wait)
		else $error("access phase without one wait state");
	AST_PREADY_ONE: assert property (pready |=> !pready)
		else $error("pready held beyond one cycle");
	AST_PREADY_REQ: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response malformed");
	AST_RD_IDLE: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside a response");
	AST_IRQ_PULSE: assert property (!irq_n |=> irq_n)
		else $error("interrupt request longer than one cycle");
	AST_TXE: assert property (ctrl_ff[7] && $rose(tx_empty_cond) |-> ##[1:2] !irq_n)
		else $error("transmit empty did not interrupt");
	AST_TXI: assert property (ctrl_ff[8] && $rose(tx_idle_cond) |-> ##[1:2] !irq_n)
		else $error("transmit idle did not interrupt");
	AST_MASKED: assert property (!irq_n |-> $past(ctrl_ff[8:6]) != 3'h0)
		else $error("interrupt with every source masked");
	AST_STAT_WR: assert property (pready && pwrite && paddr == `URX_STAT_OFS |-> !pslverr)
		else $error("status write answered with error");
endmodule
bind urx_receiver urx_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_empty_cond(tx_empty_cond),
	.tx_idle_cond(tx_idle_cond), .irq_n(irq_n));

// ### testbench/urx_serial_tx.sv
// Behavioural remote transmitter driving the receive line
`timescale 1ns/10ps
module urx_serial_tx #(
	parameter int BIT_CYC = 16
) (
	input wire logic pclk,
	output logic     rx_pin
);
	// Bench may retime the bit or flip one mid-bit sample
	int bit_cyc = BIT_CYC;
	int glitch  = -1;
	initial begin
		rx_pin = 1'b1;
	end
	// ****
	// One frame; a low stop stretches into a long break
	// ****
	task automatic send(input logic [8:0] d, input int n, input logic stp);
		@(posedge pclk);
		rx_pin <= 1'b0;
		repeat (bit_cyc) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			rx_pin <= d[i];
			if (i == glitch) begin
				repeat (bit_cyc / 2) @(posedge pclk);
				rx_pin <= ~d[i];
				@(posedge pclk);
				rx_pin <= d[i];
				repeat (bit_cyc / 2 - 1) @(posedge pclk);
			end else begin
				repeat (bit_cyc) @(posedge pclk);
			end
		end
		rx_pin <= stp;
		repeat (bit_cyc * (stp ? 1 : 4)) @(posedge pclk);
		rx_pin <= 1'b1;
		repeat (bit_cyc) @(posedge pclk);
	endtask
endmodule
